// ===== verilog/rtk_regs.svh
// Register offsets, field positions, reset values and timing counts
// of the timekeeper.
// Assumes inclusion by bare name from the package and the design.
`ifndef RTK_REGS_SVH
`define RTK_REGS_SVH

// ============================================================
// Register offsets.
`define RTK_A_TUNE    8'h96
`define RTK_A_ALSUB   8'hf2
`define RTK_A_ALSEC   8'hf3
`define RTK_A_ALMIN   8'hf4
`define RTK_A_ALHR    8'hf5
`define RTK_A_STAT    8'hf6
`define RTK_A_MASK    8'hf7
`define RTK_A_CTRL    8'hf9
`define RTK_A_SUB     8'hfa
`define RTK_A_SEC     8'hfb
`define RTK_A_MIN     8'hfc
`define RTK_A_HR      8'hfd
`define RTK_A_DAYLO   8'hfe
`define RTK_A_DAYHI   8'hff

// ============================================================
// Control and tuning register fields.
`define RTK_C_SUBME   7
`define RTK_C_SECME   6
`define RTK_C_MINME   5
`define RTK_C_HRME    4
`define RTK_C_HOLD    3
`define RTK_C_WREN    2
`define RTK_C_FLAG    1
`define RTK_C_RUN     0
`define RTK_T_LOAD    6

// ============================================================
// Status and mask fields.
`define RTK_S_ALARM   0
`define RTK_S_SEC     1
`define RTK_S_DAY     2

// ============================================================
// Reset values and timing.
`define RTK_CTRL_RST  8'h00
`define RTK_TUNE_RST  8'h00
`define RTK_XTAL_HZ   32768
`define RTK_STEPS     256
`define RTK_DIV       (`RTK_XTAL_HZ / `RTK_STEPS)
`define RTK_SEC_TOP   8'h3b
`define RTK_HR_TOP    8'h17
`define RTK_DOW_TOP   8'h06
`define RTK_SUB_TOP   8'hff

`endif

// ===== verilog/rtk_pkg.sv
// Types shared by the timekeeper design.
// Assumes rtk_regs.svh on the include path.
`include "rtk_regs.svh"

package rtk_pkg;

  // ==========================================================
  // Register port request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtk_bus_req_t;

  // ==========================================================
  // Time of day and day count.
  typedef struct packed {
    logic [7:0]  sub;
    logic [5:0]  sec;
    logic [5:0]  min;
    logic [4:0]  hr;
    logic [2:0]  dow;
    logic [15:0] day;
  } rtk_time_t;

  // ==========================================================
  // All state of the timekeeper.
  typedef struct packed {
    logic       xs1;
    logic       xs2;
    logic       xs3;
    logic       xStable;
    logic [6:0] pre;
    rtk_time_t  tm;
    logic [7:0] alSub;
    logic [5:0] alSec;
    logic [5:0] alMin;
    logic [4:0] alHr;
    logic [7:0] ctrl;
    logic [7:0] tune;
    logic [2:0] stat;
    logic [2:0] mask;
    rtk_time_t  snap;
    logic [7:0] rdata;
    logic       irq;
    logic       xOut;
    logic       loadSel;
  } rtk_state_t;

endpackage

// ===== verilog/rtk_alarm_timekeeper.sv
// Timekeeper with alarm: time of day, day count, alarm and interrupt.
// Assumes clk is the always-on clock, rstn the backup power-on reset
// and sysResetN a synchronous main-power reset from the clk domain.
//
// Contract
// - Count only from the 32.768 kHz crystal.
// - Subsecond step is 1/256 s, carries.
// - Time fields readable and writable by software.
// - Four registers give time; minutes alone.
// - Day count is unsigned 16-bit binary.
// - Alarm flag set when selected fields equal.
// - Enabled alarm flag requests interrupt always.
// - Each field separately selectable for matching.
// - No field selected matches every step.
// - Run bit starts and stops the oscillator.
// - Control bits other than the alarm flag survive main-power reset.
// - Counters keep running without main power.
// - Tuning bit 6 selects crystal load.
// - Load select survives main-power loss.
`timescale 1ns/100ps
`include "rtk_regs.svh"

module rtk_alarm_timekeeper (
  // Clock, resets and enable.
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  sysResetN,
  input  wire logic                  ce,
  // Register port.
  input  wire rtk_pkg::rtk_bus_req_t busReq,
  output logic [7:0]                 rdata,
  // Crystal pins.
  input  wire logic                  crystalInPin,
  output logic                       crystalOutPin,
  output logic                       loadSel,
  // Interrupt.
  output logic                       irq
);
  import rtk_pkg::*;

  // ==========================================================
  // Wrapping increment: carry in bit 8, next value below.
  function automatic logic [8:0] incWrap(
    input logic [7:0] v,
    input logic [7:0] top
  );
    logic [8:0] r;
    if (v >= top) begin
      r = {1'b1, 8'h00};
    end else begin
      r = {1'b0, v + 8'h01};
    end
    return r;
  endfunction

  // ==========================================================
  // State.
  rtk_state_t s_q;
  rtk_state_t s_d;

  localparam logic [6:0] DivTop = 7'(`RTK_DIV - 1);

  logic       rise;
  logic       step;
  logic       match;
  logic [8:0] iSub;
  logic [8:0] iSec;
  logic [8:0] iMin;
  logic [8:0] iHr;
  logic [8:0] iDow;
  logic [2:0] evt;
  logic [2:0] clr;
  logic       wrOk;
  rtk_time_t  rdTm;
  logic [7:0] rd;

  // ==========================================================
  // Next state.
  always_comb begin
    s_d = s_q;
    rise = 1'b0;
    step = 1'b0;
    match = 1'b0;
    evt = 3'h0;
    clr = 3'h0;
    iSub = 9'h000;
    iSec = 9'h000;
    iMin = 9'h000;
    iHr = 9'h000;
    iDow = 9'h000;
    wrOk = 1'b0;
    rdTm = s_q.tm;
    rd = 8'h00;

    // Crystal input passes three flops; agreement of two counts.
    s_d.xs1 = crystalInPin;
    s_d.xs2 = s_q.xs1;
    s_d.xs3 = s_q.xs2;
    if ((s_q.xs2 == s_q.xs3) && (s_q.xs3 != s_q.xStable)) begin
      s_d.xStable = s_q.xs3;
      rise = s_q.xs3;
    end

    // Oscillator drive follows the run bit.
    s_d.xOut = s_q.ctrl[`RTK_C_RUN] & ~s_q.xStable;

    // Prescaler gives one step per 128 crystal cycles.
    if (s_q.ctrl[`RTK_C_RUN] && rise) begin
      if (s_q.pre == DivTop) begin
        s_d.pre = 7'h00;
        step = 1'b1;
      end else begin
        s_d.pre = s_q.pre + 7'h01;
      end
    end

    // Time counters and carries.
    if (step) begin
      iSub = incWrap(s_q.tm.sub, `RTK_SUB_TOP);
      s_d.tm.sub = iSub[7:0];
      if (iSub[8]) begin
        evt[`RTK_S_SEC] = 1'b1;
        iSec = incWrap({2'h0, s_q.tm.sec}, `RTK_SEC_TOP);
        s_d.tm.sec = iSec[5:0];
        if (iSec[8]) begin
          iMin = incWrap({2'h0, s_q.tm.min}, `RTK_SEC_TOP);
          s_d.tm.min = iMin[5:0];
          if (iMin[8]) begin
            iHr = incWrap({3'h0, s_q.tm.hr}, `RTK_HR_TOP);
            s_d.tm.hr = iHr[4:0];
            if (iHr[8]) begin
              evt[`RTK_S_DAY] = 1'b1;
              iDow = incWrap({5'h00, s_q.tm.dow}, `RTK_DOW_TOP);
              s_d.tm.dow = iDow[2:0];
              s_d.tm.day = s_q.tm.day + 16'h0001;
            end
          end
        end
      end

      // Alarm compare on the new time; unselected fields match.
      match = 1'b1;
      if (s_q.ctrl[`RTK_C_SUBME] && (s_d.tm.sub != s_q.alSub)) begin
        match = 1'b0;
      end
      if (s_q.ctrl[`RTK_C_SECME] && (s_d.tm.sec != s_q.alSec)) begin
        match = 1'b0;
      end
      if (s_q.ctrl[`RTK_C_MINME] && (s_d.tm.min != s_q.alMin)) begin
        match = 1'b0;
      end
      if (s_q.ctrl[`RTK_C_HRME] && (s_d.tm.hr != s_q.alHr)) begin
        match = 1'b0;
      end
      evt[`RTK_S_ALARM] = match;
    end

    // Register writes.
    wrOk = busReq.wr & s_q.ctrl[`RTK_C_WREN];
    if (busReq.wr) begin
      case (busReq.addr)
        `RTK_A_CTRL: begin
          s_d.ctrl = busReq.wdata & 8'hfd;
        end
        `RTK_A_TUNE: begin
          s_d.tune = busReq.wdata;
        end
        `RTK_A_ALSUB: begin
          s_d.alSub = busReq.wdata;
        end
        `RTK_A_ALSEC: begin
          s_d.alSec = busReq.wdata[5:0];
        end
        `RTK_A_ALMIN: begin
          s_d.alMin = busReq.wdata[5:0];
        end
        `RTK_A_ALHR: begin
          s_d.alHr = busReq.wdata[4:0];
        end
        `RTK_A_STAT: begin
          clr = busReq.wdata[2:0];
        end
        `RTK_A_MASK: begin
          s_d.mask = busReq.wdata[2:0];
        end
        default: begin
        end
      endcase
    end

    // Time writes need the write-enable bit.
    if (wrOk) begin
      case (busReq.addr)
        `RTK_A_SUB: begin
          s_d.tm.sub = busReq.wdata;
          s_d.pre = 7'h00;
        end
        `RTK_A_SEC: begin
          s_d.tm.sec = busReq.wdata[5:0];
        end
        `RTK_A_MIN: begin
          s_d.tm.min = busReq.wdata[5:0];
        end
        `RTK_A_HR: begin
          s_d.tm.hr = busReq.wdata[4:0];
          s_d.tm.dow = busReq.wdata[7:5];
        end
        `RTK_A_DAYLO: begin
          s_d.tm.day[7:0] = busReq.wdata;
        end
        `RTK_A_DAYHI: begin
          s_d.tm.day[15:8] = busReq.wdata;
        end
        default: begin
        end
      endcase
    end

    // Sticky status: a new event wins over its clear.
    s_d.stat = (s_q.stat & ~clr) | evt;
    s_d.ctrl[`RTK_C_FLAG] = s_d.stat[`RTK_S_ALARM];

    // Snapshot follows the time until the hold bit is set.
    if (!s_q.ctrl[`RTK_C_HOLD]) begin
      s_d.snap = s_d.tm;
    end
    if (s_q.ctrl[`RTK_C_HOLD]) begin
      rdTm = s_q.snap;
    end

    // Read mux; data stand only in the cycle after the strobe.
    case (busReq.addr)
      `RTK_A_CTRL: begin
        rd = s_q.ctrl;
      end
      `RTK_A_TUNE: begin
        rd = s_q.tune;
      end
      `RTK_A_ALSUB: begin
        rd = s_q.alSub;
      end
      `RTK_A_ALSEC: begin
        rd = {2'h0, s_q.alSec};
      end
      `RTK_A_ALMIN: begin
        rd = {2'h0, s_q.alMin};
      end
      `RTK_A_ALHR: begin
        rd = {3'h0, s_q.alHr};
      end
      `RTK_A_STAT: begin
        rd = {5'h00, s_q.stat};
      end
      `RTK_A_MASK: begin
        rd = {5'h00, s_q.mask};
      end
      `RTK_A_SUB: begin
        rd = rdTm.sub;
      end
      `RTK_A_SEC: begin
        rd = {2'h0, rdTm.sec};
      end
      `RTK_A_MIN: begin
        rd = {2'h0, rdTm.min};
      end
      `RTK_A_HR: begin
        rd = {rdTm.dow, rdTm.hr};
      end
      `RTK_A_DAYLO: begin
        rd = rdTm.day[7:0];
      end
      `RTK_A_DAYHI: begin
        rd = rdTm.day[15:8];
      end
      default: begin
        rd = 8'h00;
      end
    endcase
    s_d.rdata = busReq.rd ? rd : 8'h00;

    // Main-power reset clears only bus-side state.
    if (!sysResetN) begin
      s_d.stat = 3'h0;
      s_d.mask = 3'h0;
      s_d.rdata = 8'h00;
      s_d.ctrl[`RTK_C_FLAG] = 1'b0;
    end

    // Interrupt follows flags and their enables.
    s_d.irq = |(s_d.stat & s_d.mask);
    s_d.loadSel = s_d.tune[`RTK_T_LOAD];
  end

  // ==========================================================
  // State register, on the always-on supply.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs.
  assign rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign crystalOutPin = s_q.xOut;
  assign loadSel = s_q.loadSel;

endmodule

// ===== sim/rtk_alarm_timekeeper_chk.sv
// Port assertions for the timekeeper with alarm.
// Assumes binding into rtk_alarm_timekeeper, one clock domain.
`timescale 1ns/100ps
`include "rtk_regs.svh"

// ==========================================================
// Checker
module rtk_alarm_timekeeper_chk (
  // Clock and resets.
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic                  sysResetN,
  input wire logic                  ce,
  // Register port.
  input wire rtk_pkg::rtk_bus_req_t busReq,
  input wire logic [7:0]            rdata,
  // Pins and interrupt.
  input wire logic                  crystalInPin,
  input wire logic                  crystalOutPin,
  input wire logic                  loadSel,
  input wire logic                  irq
);
  import rtk_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic tuneWr;
  logic statWr;
  assign tuneWr = ce && busReq.wr && busReq.addr == `RTK_A_TUNE;
  assign statWr = busReq.wr && busReq.addr inside {`RTK_A_STAT, `RTK_A_MASK};

  property p_rdIdle;
    $past(ce) && !$past(ce && busReq.rd) |-> rdata == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("stray rdata");
  property p_freeze;
    !ce |=> $stable(rdata) && $stable(irq);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while off");
  property p_sysRst;
    ce && !sysResetN |=> !irq && rdata == 8'h00;
  endproperty
  a_sysRst: assert property (p_sysRst) else $error("irq after reset");
  property p_tune;
    tuneWr |=> loadSel == $past(busReq.wdata[`RTK_T_LOAD]);
  endproperty
  a_tune: assert property (p_tune) else $error("load select wrong");
  property p_keep;
    !tuneWr |=> $stable(loadSel);
  endproperty
  a_keep: assert property (p_keep) else $error("load select lost");
  property p_irqFall;
    $fell(irq) |-> $past(!sysResetN || statWr);
  endproperty
  a_irqFall: assert property (p_irqFall) else $error("irq dropped");
  property p_alReg;
    ce && busReq.wr && busReq.addr == `RTK_A_ALSUB ##2
      ce && busReq.rd && busReq.addr == `RTK_A_ALSUB
      |=> rdata == $past(busReq.wdata, 3);
  endproperty
  a_alReg: assert property (p_alReg) else $error("alarm reg");
  property p_irqMask;
    ce && busReq.wr && busReq.addr == `RTK_A_MASK && busReq.wdata == 8'h00
      |-> ##2 !irq;
  endproperty
  a_irqMask: assert property (p_irqMask) else $error("masked irq");
  c_irq: cover property ($rose(irq));
  c_sysRst: cover property (ce && !sysResetN);
  c_tune: cover property (tuneWr);
endmodule

bind rtk_alarm_timekeeper rtk_alarm_timekeeper_chk uChk (
  .clk(clk), .rstn(rstn), .sysResetN(sysResetN), .ce(ce), .busReq(busReq),
  .rdata(rdata), .crystalInPin(crystalInPin), .crystalOutPin(crystalOutPin),
  .loadSel(loadSel), .irq(irq));

// ===== sim/rtk_xtal_model.sv
// Behavioural timekeeping crystal across the two crystal pins.
// Assumes the device drives crystalOutPin only while its oscillator runs.
`timescale 1ns/100ps

// ==========================================================
// Resonator
module rtk_xtal_model #(
  parameter int HALF_NS = 400
) (
  // Crystal pins.
  input  wire logic crystalOutPin,
  output logic      crystalInPin
);
  // The swing follows the drive; with no drive it settles low.
  initial crystalInPin = 1'b0;
  always @(crystalOutPin) crystalInPin <= #(HALF_NS) crystalOutPin;
endmodule

// ===== sim/rtk_alarm_timekeeper_bench.sv
// Self-checking bench for the timekeeper with alarm.
// Assumes the design, its package, the crystal model and the checker.
`timescale 1ns/100ps
`include "rtk_regs.svh"

// ==========================================================
// Bench
module rtk_alarm_timekeeper_bench;
  import rtk_pkg::*;
  logic         clk;
  logic         rstn;
  logic         sysResetN;
  logic         ce;
  rtk_bus_req_t busReq;
  logic [7:0]   rdata;
  logic [7:0]   rv;
  logic         xIn;
  logic         xOut;
  logic         loadSel;
  logic         irq;
  int           mismatches;
  int           checkCount;
  int           cyc;

  always #50 clk = ~clk;
  rtk_alarm_timekeeper uut (
    .clk(clk), .rstn(rstn), .sysResetN(sysResetN), .ce(ce), .busReq(busReq),
    .rdata(rdata), .crystalInPin(xIn), .crystalOutPin(xOut),
    .loadSel(loadSel), .irq(irq));
  rtk_xtal_model xtal (.crystalOutPin(xOut), .crystalInPin(xIn));

  // ========================================================
  // Tasks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checkCount++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) busReq.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk) busReq.rd <= 1'b0;
    @(negedge clk) rv = rdata;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic poll;
    rv = 8'h00;
    for (int i = 0; i < 4000 && rv[0] !== 1'b1; i++) rd(`RTK_A_STAT);
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ========================================================
  // Tests
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    sysResetN = 1'b1;
    ce = 1'b1;
    busReq = '0;
    mismatches = 0;
    checkCount = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(8'h00, 8'h00);
    wr(`RTK_A_TUNE, 8'h40);
    chk({7'h00, loadSel}, 8'h01);
    rdc(`RTK_A_TUNE, 8'h40);
    wr(`RTK_A_ALSUB, 8'ha5);
    rdc(`RTK_A_ALSUB, 8'ha5);
    $display("Registers test done");
    wr(`RTK_A_CTRL, 8'h04);
    wr(`RTK_A_SUB, 8'hff);
    wr(`RTK_A_SEC, 8'h3b);
    wr(`RTK_A_MIN, 8'h3b);
    wr(`RTK_A_HR, 8'hd7);
    wr(`RTK_A_DAYLO, 8'hff);
    wr(`RTK_A_DAYHI, 8'hff);
    rdc(`RTK_A_MIN, 8'h3b);
    rdc(`RTK_A_HR, 8'hd7);
    wr(`RTK_A_MASK, 8'h07);
    wr(`RTK_A_CTRL, 8'h05);
    poll();
    chk(rv, 8'h07);
    chk({7'h00, irq}, 8'h01);
    rdc(`RTK_A_SUB, 8'h00);
    rdc(`RTK_A_SEC, 8'h00);
    rdc(`RTK_A_MIN, 8'h00);
    rdc(`RTK_A_HR, 8'h00);
    rdc(`RTK_A_DAYLO, 8'h00);
    rdc(`RTK_A_DAYHI, 8'h00);
    wr(`RTK_A_STAT, 8'h07);
    chk({7'h00, irq}, 8'h00);
    rdc(`RTK_A_STAT, 8'h00);
    $display("Rollover test done");
    wr(`RTK_A_MASK, 8'h00);
    poll();
    chk(rv, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(`RTK_A_MASK, 8'h01);
    chk({7'h00, irq}, 8'h01);
    sysResetN <= 1'b0;
    @(posedge clk) sysResetN <= 1'b1;
    @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rdc(`RTK_A_CTRL, 8'h05);
    rdc(`RTK_A_TUNE, 8'h40);
    $display("Mask test done");
    wr(`RTK_A_CTRL, 8'h04);
    wr(`RTK_A_SUB, 8'h10);
    wr(`RTK_A_ALSUB, 8'h12);
    wr(`RTK_A_ALSEC, 8'h00);
    wr(`RTK_A_ALMIN, 8'h00);
    wr(`RTK_A_ALHR, 8'h00);
    wr(`RTK_A_STAT, 8'h07);
    wr(`RTK_A_MASK, 8'h01);
    wr(`RTK_A_CTRL, 8'hf5);
    poll();
    rdc(`RTK_A_SUB, 8'h12);
    chk({7'h00, irq}, 8'h01);
    wr(`RTK_A_CTRL, 8'h04);
    repeat (3000) @(posedge clk);
    rdc(`RTK_A_SUB, 8'h12);
    chk({7'h00, xOut}, 8'h00);
    wr(`RTK_A_CTRL, 8'h0d);
    repeat (3000) @(posedge clk);
    rdc(`RTK_A_SUB, 8'h12);
    wr(`RTK_A_CTRL, 8'h05);
    rdc(`RTK_A_SUB, 8'h13);
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    $display("Match test done");
    wrap_up();
  end
endmodule
